// [cla_pkg.sv]
// constants for the conversion limit alert register bank
// Notes on behaviour
// - channel 0 over flag sets on result above high limit, sticky until flag read
// - channel 0 under flag sets on result below low limit, sticky until flag read
// - channels 1..3 have same sticky flags in bits 7..2, channel 3 over topmost
// - written 12-bit low field forms low compare bits 15:4, resets to 0x800
// - low compare bits 3:0 are always zero
// - under alert when result below low compare value, never when above
// - written 12-bit high field forms high compare bits 15:4, resets to 0x7FF
// - high compare bits 3:0 are always ones
// - over alert when result above high compare value, never when below
// - register word bits 15:12 select the register, bits 11:0 carry the value; the count word uses all bits 15:0 for the count
package cla_pkg;
  localparam int          NUM_CHAN      = 4;
  localparam int          RES_W         = 16;
  localparam int          LIM_W         = 12;
  localparam int          SEL_W         = 4;
  localparam int          FLAG_W        = 2 * NUM_CHAN;
  // apb byte offsets
  localparam logic [7:0]  OFS_FLAGS     = 8'h00;
  localparam logic [7:0]  OFS_LOW       = 8'h04;
  localparam logic [7:0]  OFS_HIGH      = 8'h08;
  localparam logic [7:0]  OFS_CMD       = 8'h0C;
  localparam logic [7:0]  OFS_COUNT     = 8'h10;
  // register select codes carried in word bits 15:12
  localparam logic [3:0]  SEL_FLAGS     = 4'h1;
  localparam logic [3:0]  SEL_LOW       = 4'h2;
  localparam logic [3:0]  SEL_HIGH      = 4'h3;
  // field positions
  localparam int          SEL_LSB       = 12;
  localparam int          LIM_LSB       = 0;
  localparam int          LIM_POS       = 4;
  // reset and fixed values
  localparam logic [11:0] LOW_RESET     = 12'h800;
  localparam logic [11:0] HIGH_RESET    = 12'h7FF;
  localparam logic [3:0]  LOW_FILL      = 4'h0;
  localparam logic [3:0]  HIGH_FILL     = 4'hF;
  localparam logic [7:0]  FLAGS_RESET   = 8'h00;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;
endpackage : cla_pkg

// [cla_limit_alert.sv]
// apb register bank with per-channel limit compare and sticky alert flags
`timescale 1ns/1ps
module cla_limit_alert #(
  parameter int NUM_CHAN = cla_pkg::NUM_CHAN,
  parameter int RES_W    = cla_pkg::RES_W
) (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   conv_done,
  input  wire logic [RES_W-1:0]       conv_res0,
  input  wire logic [RES_W-1:0]       conv_res1,
  input  wire logic [RES_W-1:0]       conv_res2,
  input  wire logic [RES_W-1:0]       conv_res3,
  output logic      [2*NUM_CHAN-1:0]  alert_flags
);

  localparam int FW = 2 * NUM_CHAN;

  logic [cla_pkg::LIM_W-1:0] low_limit;
  logic [cla_pkg::LIM_W-1:0] high_limit;
  logic [FW-1:0]             flags;
  logic [15:0]               conv_count;
  logic [RES_W-1:0]          res [NUM_CHAN];
  logic [RES_W-1:0]          low_cmp;
  logic [RES_W-1:0]          high_cmp;
  logic [FW-1:0]             next_set;
  logic                      xfer_done;
  logic                      wr_done;
  logic                      rd_done;
  logic                      flag_rd;
  logic [FW-1:0]             clr_mask;
  logic                      mapped;
  logic [cla_pkg::SEL_W-1:0] wsel;
  logic [cla_pkg::LIM_W-1:0] wval;
  logic                      wr_low;
  logic                      wr_high;
  logic [31:0]               next_rdata;

  assign res[0] = conv_res0;
  assign res[1] = conv_res1;
  assign res[2] = conv_res2;
  assign res[3] = conv_res3;

  // widened compare values; fixed fill makes both limits inclusive of whole lsb step
  assign low_cmp  = {low_limit, cla_pkg::LOW_FILL};
  assign high_cmp = {high_limit, cla_pkg::HIGH_FILL};

  // results are two's complement, so 0x800 low / 0x7FF high reset means never alert
  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_cmp
      assign next_set[2*g]   = conv_done && ($signed(res[g]) < $signed(low_cmp));
      assign next_set[2*g+1] = conv_done && ($signed(res[g]) > $signed(high_cmp));
    end
  endgenerate

  // apb handshake: pready is registered, so every access has no wait state
  assign xfer_done = psel && penable && pready;
  assign wr_done   = xfer_done && pwrite && !pslverr;
  assign rd_done   = xfer_done && !pwrite && !pslverr;
  assign flag_rd   = rd_done && (paddr == cla_pkg::OFS_FLAGS);
  // clear only what the read word showed; an alert landing on the setup edge
  // misses the snapshot and would otherwise vanish unseen
  assign clr_mask  = flag_rd ? prdata[FW-1:0] : '0;

  assign mapped = (paddr == cla_pkg::OFS_FLAGS) || (paddr == cla_pkg::OFS_LOW) ||
                  (paddr == cla_pkg::OFS_HIGH)  || (paddr == cla_pkg::OFS_CMD) ||
                  (paddr == cla_pkg::OFS_COUNT);

  assign wsel = pwdata[cla_pkg::SEL_LSB +: cla_pkg::SEL_W];
  assign wval = pwdata[cla_pkg::LIM_LSB +: cla_pkg::LIM_W];

  // select code must name the target; a mismatched word is dropped silently
  always_comb begin
    wr_low  = 1'b0;
    wr_high = 1'b0;
    if (wr_done) begin
      unique case (paddr)
        cla_pkg::OFS_LOW:  wr_low  = (wsel == cla_pkg::SEL_LOW);
        cla_pkg::OFS_HIGH: wr_high = (wsel == cla_pkg::SEL_HIGH);
        cla_pkg::OFS_CMD: begin
          wr_low  = (wsel == cla_pkg::SEL_LOW);
          wr_high = (wsel == cla_pkg::SEL_HIGH);
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    next_rdata = cla_pkg::RDATA_RESET;
    unique case (paddr)
      cla_pkg::OFS_FLAGS: next_rdata[15:0] = {cla_pkg::SEL_FLAGS,
                                              {(cla_pkg::LIM_W - FW){1'b0}}, flags};
      cla_pkg::OFS_LOW:   next_rdata[15:0] = {cla_pkg::SEL_LOW, low_limit};
      cla_pkg::OFS_HIGH:  next_rdata[15:0] = {cla_pkg::SEL_HIGH, high_limit};
      cla_pkg::OFS_COUNT: next_rdata[15:0] = conv_count;
      default:            next_rdata = cla_pkg::RDATA_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= cla_pkg::RDATA_RESET;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable) begin
        prdata <= next_rdata;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_limit <= cla_pkg::LOW_RESET;
    end else if (wr_low) begin
      low_limit <= wval;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      high_limit <= cla_pkg::HIGH_RESET;
    end else if (wr_high) begin
      high_limit <= wval;
    end
  end

  // read clears, but an alert in the same cycle survives the clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags <= cla_pkg::FLAGS_RESET;
    end else if (flag_rd) begin
      flags <= (flags & ~clr_mask) | next_set;
    end else begin
      flags <= flags | next_set;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      alert_flags <= cla_pkg::FLAGS_RESET;
    end else if (flag_rd) begin
      alert_flags <= (flags & ~clr_mask) | next_set;
    end else begin
      alert_flags <= flags | next_set;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_count <= cla_pkg::COUNT_RESET;
    end else if (conv_done) begin
      conv_count <= conv_count + 16'h0001;
    end
  end

  // ---- checks ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_over_sets_sticky: assert property (
    conv_done && $signed(conv_res0) > $signed({high_limit, cla_pkg::HIGH_FILL})
    |=> flags[1])
    else $error("channel 0 over flag not set");

  a_under_sets_sticky: assert property (
    conv_done && $signed(conv_res0) < $signed({low_limit, cla_pkg::LOW_FILL})
    |=> flags[0])
    else $error("channel 0 under flag not set");

  a_flag_holds: assert property (
    $past(flags[FW-1]) && !$past(flag_rd) |-> flags[FW-1])
    else $error("channel 3 over flag dropped without read");

  a_chan3_over_pos: assert property (
    conv_done && $signed(conv_res3) > $signed(high_cmp) |=> flags[7])
    else $error("channel 3 over flag not at bit 7");

  a_low_fill_zero: assert property (
    low_cmp[3:0] == cla_pkg::LOW_FILL && low_cmp[15:4] == low_limit)
    else $error("low compare value malformed");

  a_high_fill_ones: assert property (
    high_cmp[3:0] == cla_pkg::HIGH_FILL && high_cmp[15:4] == high_limit)
    else $error("high compare value malformed");

  a_no_under_above: assert property (
    conv_done && $signed(conv_res1) >= $signed(low_cmp) && !flags[2]
    && !(psel && penable) |=> !flags[2])
    else $error("channel 1 under flag set while result at or above limit");

  a_no_over_below: assert property (
    conv_done && $signed(conv_res2) <= $signed(high_cmp) && !flags[5]
    && !(psel && penable) |=> !flags[5])
    else $error("channel 2 over flag set while result at or below limit");

  a_low_write_applies: assert property (
    wr_done && paddr == cla_pkg::OFS_LOW && pwdata[15:12] == cla_pkg::SEL_LOW
    |=> low_limit == $past(pwdata[11:0]))
    else $error("low limit write not applied");

  a_bad_sel_dropped: assert property (
    wr_done && paddr == cla_pkg::OFS_HIGH && pwdata[15:12] != cla_pkg::SEL_HIGH
    |=> $stable(high_limit))
    else $error("high limit written with wrong select code");

  a_read_clears: assert property (
    flag_rd && !conv_done && flags == prdata[FW-1:0]
    |=> flags == '0)
    else $error("flag read did not clear flags");

  a_zero_wait: assert property (
    psel && !penable |=> pready)
    else $error("apb access phase lacks pready");

  // read-clear races, bit placement and bus refusal
  a_set_beats_clear: assert property (
    flag_rd && next_set[1]
    |=> flags[1])
    else $error("alert on the clearing edge was lost");

  a_unread_kept: assert property (
    flag_rd && flags[1] && !prdata[1]
    |=> flags[1])
    else $error("unreported over flag cleared by read");

  a_under_holds: assert property (
    $past(flags[0]) && !$past(flag_rd)
    |-> flags[0])
    else $error("channel 0 under flag dropped without read");

  a_high_write_applies: assert property (
    wr_done && paddr == cla_pkg::OFS_HIGH && pwdata[15:12] == cla_pkg::SEL_HIGH
    |=> high_limit == $past(pwdata[11:0]))
    else $error("high limit write not applied");

  a_cmd_routes_high: assert property (
    wr_done && paddr == cla_pkg::OFS_CMD && pwdata[15:12] == cla_pkg::SEL_HIGH
    |=> high_limit == $past(pwdata[11:0]))
    else $error("command word did not reach high limit");

  a_bad_sel_low: assert property (
    wr_done && paddr == cla_pkg::OFS_LOW && pwdata[15:12] != cla_pkg::SEL_LOW
    |=> $stable(low_limit))
    else $error("low limit written with wrong select code");

  a_flags_readback: assert property (
    psel && !penable && paddr == cla_pkg::OFS_FLAGS
    |=> prdata[FW-1:0] == $past(flags))
    else $error("flag read word does not show flags");

  a_chan1_over_pos: assert property (
    conv_done && $signed(conv_res1) > $signed(high_cmp)
    |=> flags[3])
    else $error("channel 1 over flag not at bit 3");

  a_chan2_under_pos: assert property (
    conv_done && $signed(conv_res2) < $signed(low_cmp)
    |=> flags[4])
    else $error("channel 2 under flag not at bit 4");

  a_chan3_under_pos: assert property (
    conv_done && $signed(conv_res3) < $signed(low_cmp)
    |=> flags[6])
    else $error("channel 3 under flag not at bit 6");

  a_flags_idle: assert property (
    !conv_done && !flag_rd
    |=> $stable(flags))
    else $error("flags changed without conversion or read");

  a_unmapped_err: assert property (
    psel && !penable && !mapped
    |=> pslverr && prdata == cla_pkg::RDATA_RESET)
    else $error("unmapped access not refused");

  a_ready_one_cycle: assert property (
    pready |=> !pready)
    else $error("pready held past the access cycle");

  a_count_step: assert property (
    conv_done |=> conv_count == $past(conv_count) + 16'h0001)
    else $error("conversion count did not advance");

  // scenarios the bench is expected to reach
  c_over_alert: cover property (conv_done ##1 flags[1]);
  c_read_clear: cover property (flags != '0 ##1 rd_done && paddr == cla_pkg::OFS_FLAGS);
  c_set_on_clear: cover property (rd_done && paddr == cla_pkg::OFS_FLAGS && next_set != '0);
  c_cmd_write: cover property (wr_done && paddr == cla_pkg::OFS_CMD && wr_high);
  c_late_set_kept: cover property (flag_rd && flags[1] && !prdata[1]);

endmodule : cla_limit_alert

// [cla_host_model.sv]
// host controller model issuing apb transfers
`timescale 1ns/1ps
module cla_host_model (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end
  // holds the request until pready is seen high, giving up as hung after 16 access cycles
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output logic hung);
    hung = 1'b1;
    rd   = 32'h0;
    err  = 1'b0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (int i = 0; i < 16 && hung; i++) begin
      @(posedge clk);
      if (pready === 1'b1) begin
        hung = 1'b0;
        rd   = prdata;
        err  = pslverr;
      end
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    // stale data must not look valid after release
    pwdata  <= ~d;
  endtask : xfer
endmodule : cla_host_model

// [tb_top.sv]
// self-checking bench for the limit alert register bank
`timescale 1ns/1ps
module tb_top;
  typedef struct {
    logic [11:0]      lo;
    logic [11:0]      hi;
    logic [3:0][15:0] r;
    logic [7:0]       fl;
  } cla_row_s;
  logic             clk;
  logic             arst_n;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [7:0]       paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             conv_done;
  logic [3:0][15:0] res;
  logic [7:0]       alert_flags;
  logic [31:0]      rd;
  logic             er;
  int               err_count;
  int               check_count;
  // boundary results sit exactly on the compare values
  cla_row_s rows [4] = '{
    '{12'h800, 12'h7FF, {16'h1234, 16'h0000, 16'h7FFF, 16'h8000}, 8'h00},
    '{12'h000, 12'h100, {16'h0000, 16'h100F, 16'hFFFF, 16'h1010}, 8'h06},
    '{12'hF00, 12'h0FF, {16'h7FFF, 16'h8000, 16'h1000, 16'hEFFF}, 8'h99},
    '{12'h000, 12'h000, {16'hFFFF, 16'h0010, 16'h0000, 16'h0005}, 8'h60}};

  cla_limit_alert dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_done(conv_done), .conv_res0(res[0]), .conv_res1(res[1]),
    .conv_res2(res[2]), .conv_res3(res[3]), .alert_flags(alert_flags));
  cla_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic close_out();
    if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic hung;
    host.xfer(wr, a, d, rd, er, hung);
    if (hung) begin
      err_count++;
      close_out();
    end
  endtask : bus
  task automatic conv(input logic [3:0][15:0] r);
    @(posedge clk);
    conv_done <= 1'b1;
    res       <= r;
    @(posedge clk);
    conv_done <= 1'b0;
    res       <= ~r;
  endtask : conv

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    arst_n      = 1'b0;
    conv_done   = 1'b0;
    res         = '0;
    err_count   = 0;
    check_count = 0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, cla_pkg::OFS_LOW, {16'h0, cla_pkg::SEL_LOW, rows[i].lo});
      bus(1'b1, cla_pkg::OFS_HIGH, {16'h0, cla_pkg::SEL_HIGH, rows[i].hi});
      conv(rows[i].r);
      @(negedge clk);
      chk({24'h0, alert_flags}, {24'h0, rows[i].fl});
      bus(1'b0, cla_pkg::OFS_FLAGS, 32'h0);
      chk(rd, {16'h0, cla_pkg::SEL_FLAGS, 4'h0, rows[i].fl});
      bus(1'b0, cla_pkg::OFS_FLAGS, 32'h0);
      chk(rd, {16'h0, cla_pkg::SEL_FLAGS, 12'h0});
    end
    // flag must survive a later clean conversion
    conv({16'h0005, 16'h0005, 16'h0005, 16'hFFFF});
    conv({4{16'h0005}});
    bus(1'b0, cla_pkg::OFS_FLAGS, 32'h0);
    chk(rd, {16'h0, cla_pkg::SEL_FLAGS, 12'h001});
    // alert on the setup edge, then on the clearing edge, of a flag read
    for (int k = 0; k < 2; k++) begin
      fork
        bus(1'b0, cla_pkg::OFS_FLAGS, 32'h0);
        begin
          repeat (k) @(posedge clk);
          conv({16'h0005, 16'h0005, 16'h0005, 16'h7FFF});
        end
      join
      chk(rd, {16'h0, cla_pkg::SEL_FLAGS, 12'h000});
      bus(1'b0, cla_pkg::OFS_FLAGS, 32'h0);
      chk(rd, {16'h0, cla_pkg::SEL_FLAGS, 12'h002});
    end
    bus(1'b1, cla_pkg::OFS_LOW, {16'h0, cla_pkg::SEL_HIGH, 12'h123});
    bus(1'b0, cla_pkg::OFS_LOW, 32'h0);
    chk(rd, {16'h0, cla_pkg::SEL_LOW, 12'h000});
    bus(1'b1, cla_pkg::OFS_HIGH, {16'h0, cla_pkg::SEL_LOW, 12'h456});
    bus(1'b0, cla_pkg::OFS_HIGH, 32'h0);
    chk(rd, {16'h0, cla_pkg::SEL_HIGH, 12'h000});
    bus(1'b0, 8'h14, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    conv({16'h0005, 16'h0005, 16'h0005, 16'h7FFF});
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    chk({24'h0, alert_flags}, 32'h0);
    bus(1'b0, cla_pkg::OFS_LOW, 32'h0);
    chk(rd, {16'h0, cla_pkg::SEL_LOW, 12'h800});
    bus(1'b0, cla_pkg::OFS_HIGH, 32'h0);
    chk(rd, {16'h0, cla_pkg::SEL_HIGH, 12'h7FF});
    bus(1'b1, cla_pkg::OFS_CMD, {16'h0, cla_pkg::SEL_HIGH, 12'h0F0});
    bus(1'b0, cla_pkg::OFS_HIGH, 32'h0);
    chk(rd, {16'h0, cla_pkg::SEL_HIGH, 12'h0F0});
    conv({16'h0000, 16'h0000, 16'h0F0F, 16'h0F10});
    @(negedge clk);
    chk({24'h0, alert_flags}, 32'h2);
    bus(1'b0, cla_pkg::OFS_COUNT, 32'h0);
    chk(rd, 32'h1);
    close_out();
  end
endmodule : tb_top
